// [hdl/rtm_pkg.sv]
package rtm_pkg;
    // register offsets (byte addresses, timer 0 instance)
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'hf00;
    localparam logic [11:0] ADDR_COUNT_LOW = 12'hf01;
    localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hf02;
    localparam logic [11:0] ADDR_RELOAD_LOW = 12'hf03;
    localparam logic [11:0] ADDR_MATCH_HIGH = 12'hf04;
    localparam logic [11:0] ADDR_MATCH_LOW = 12'hf05;
    localparam logic [11:0] ADDR_CTRL_ZERO = 12'hf06;
    localparam logic [11:0] ADDR_CTRL_ONE = 12'hf07;
    // control register 0 fields
    localparam int CTL0_MODE_TOP = 7;
    localparam int CTL0_IRQSEL_HI = 6;
    localparam int CTL0_IRQSEL_LO = 5;
    localparam int CTL0_DEAD_HI = 3;
    localparam int CTL0_DEAD_LO = 1;
    localparam int CTL0_CAPFLAG = 0;
    // control register 1 fields
    localparam int CTL1_ENABLE = 7;
    localparam int CTL1_POL = 6;
    localparam int CTL1_PRE_HI = 5;
    localparam int CTL1_PRE_LO = 3;
    localparam int CTL1_MODE_HI = 2;
    localparam int CTL1_MODE_LO = 0;
    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0001;
    localparam logic [15:0] MATCH_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'hffff;
    localparam logic [15:0] RESTART_COUNT = 16'h0001;
    // interrupt event selection
    localparam logic [1:0] IRQ_BOTH = 2'b00;
    localparam logic [1:0] IRQ_CAPTURE_ONLY = 2'b10;
    localparam logic [1:0] IRQ_RELOAD_ONLY = 2'b11;
    // mode codes: {mode_top_bit, mode_field}
    localparam logic [3:0] MODE_ONE_SHOT = 4'h0;
    localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
    localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
    localparam logic [3:0] MODE_CAPTURE = 4'h4;
    localparam logic [3:0] MODE_CAPTURE_RESTART = 4'h8;
endpackage

// [hdl/rtm_timer.sv]
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module rtm_timer
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic timer_in,
    output logic timer_out,
    output logic timer_out_en,
    output logic timer_irq
);
    import rtm_pkg::*;

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] match;
        logic [7:0] count_low_latch;
        logic [6:0] pre_cnt;
        logic out_level;
        logic [1:0] in_sync;
        logic in_prev;
        logic irq;
        logic [7:0] rdata;
    } rtm_state_t;

    rtm_state_t st_reg;
    rtm_state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // prescale divisor is a power of two, 1 to 128
    function automatic logic [6:0] pre_mask(input logic [2:0] sel);
        pre_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction

    function automatic logic [7:0] read_mux(input rtm_state_t s, input logic [11:0] a);
        case (a)
            ADDR_COUNT_HIGH: read_mux = s.count[15:8];
            // low count byte is the copy taken when the high byte was read
            ADDR_COUNT_LOW: read_mux = s.count_low_latch;
            ADDR_RELOAD_HIGH: read_mux = s.reload[15:8];
            ADDR_RELOAD_LOW: read_mux = s.reload[7:0];
            ADDR_MATCH_HIGH: read_mux = s.match[15:8];
            ADDR_MATCH_LOW: read_mux = s.match[7:0];
            ADDR_CTRL_ZERO: read_mux = s.ctl0;
            ADDR_CTRL_ONE: read_mux = s.ctl1;
            default: read_mux = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] mode;
    logic enabled;
    logic polarity;
    logic tick;
    logic at_reload;
    logic at_match;
    logic in_edge;
    logic rise;
    logic fall;
    logic capture_mode;

    assign mode = {st_reg.ctl0[CTL0_MODE_TOP], st_reg.ctl1[CTL1_MODE_HI:CTL1_MODE_LO]};
    assign enabled = st_reg.ctl1[CTL1_ENABLE];
    assign polarity = st_reg.ctl1[CTL1_POL];
    assign tick = enabled && ((st_reg.pre_cnt & pre_mask(st_reg.ctl1[CTL1_PRE_HI:CTL1_PRE_LO]))
                  == pre_mask(st_reg.ctl1[CTL1_PRE_HI:CTL1_PRE_LO]));
    assign at_match = st_reg.count == st_reg.match;
    assign at_reload = st_reg.count == st_reg.reload;
    assign rise = st_reg.in_sync[1] && !st_reg.in_prev;
    assign fall = !st_reg.in_sync[1] && st_reg.in_prev;
    assign in_edge = enabled && (polarity ? rise : fall);
    assign capture_mode = (mode == MODE_CAPTURE) || (mode == MODE_CAPTURE_RESTART);

    always_comb
    begin
        logic cap_irq;
        logic rel_irq;
        cap_irq = 1'b0;
        rel_irq = 1'b0;
        st_next = st_reg;
        st_next.in_sync = {st_reg.in_sync[0], timer_in};
        st_next.in_prev = st_reg.in_sync[1];
        st_next.rdata = 8'h00;
        // prescaler cleared and count frozen while disabled
        if (enabled)
        begin
            st_next.pre_cnt = st_reg.pre_cnt + 7'h01;
        end
        else
        begin
            st_next.pre_cnt = 7'h00;
            st_next.out_level = polarity;
        end
        if (tick)
        begin
            if (at_reload)
            begin
                // every later pass restarts at 0001
                st_next.count = RESTART_COUNT;
                if (mode == MODE_ONE_SHOT)
                begin
                    st_next.ctl1[CTL1_ENABLE] = 1'b0;
                end
                if (mode == MODE_CONTINUOUS || mode == MODE_ONE_SHOT)
                begin
                    st_next.out_level = !st_reg.out_level;
                end
                if (mode == MODE_PWM_SINGLE)
                begin
                    st_next.out_level = polarity;
                end
                rel_irq = 1'b1;
            end
            else
            begin
                st_next.count = st_reg.count + 16'h0001;
                if (mode == MODE_PWM_SINGLE && at_match)
                begin
                    st_next.out_level = !st_reg.out_level;
                end
            end
        end
        if (capture_mode && in_edge)
        begin
            // capture current count into the pair
            st_next.match = st_reg.count;
            if (mode == MODE_CAPTURE_RESTART)
            begin
                st_next.count = RESTART_COUNT;
                st_next.pre_cnt = 7'h00;
            end
            cap_irq = 1'b1;
        end
        // software access
        if (reg_read)
        begin
            st_next.rdata = read_mux(st_reg, reg_addr);
            if (reg_addr == ADDR_COUNT_HIGH)
            begin
                st_next.count_low_latch = st_reg.count[7:0];
            end
        end
        if (reg_write)
        begin
            case (reg_addr)
                ADDR_COUNT_HIGH: st_next.count[15:8] = reg_wdata;
                ADDR_COUNT_LOW: st_next.count[7:0] = reg_wdata;
                ADDR_RELOAD_HIGH: st_next.reload[15:8] = reg_wdata;
                ADDR_RELOAD_LOW: st_next.reload[7:0] = reg_wdata;
                ADDR_MATCH_HIGH: st_next.match[15:8] = reg_wdata;
                ADDR_MATCH_LOW: st_next.match[7:0] = reg_wdata;
                ADDR_CTRL_ZERO: st_next.ctl0 = reg_wdata;
                ADDR_CTRL_ONE: st_next.ctl1 = reg_wdata;
                default: st_next.ctl1 = st_next.ctl1;
            endcase
        end
        // hardware status wins over a software write
        if (capture_mode && cap_irq)
        begin
            st_next.ctl0[CTL0_CAPFLAG] = 1'b1;
        end
        else if (capture_mode && rel_irq)
        begin
            st_next.ctl0[CTL0_CAPFLAG] = 1'b0;
        end
        case (st_reg.ctl0[CTL0_IRQSEL_HI:CTL0_IRQSEL_LO])
            IRQ_CAPTURE_ONLY: st_next.irq = cap_irq;
            IRQ_RELOAD_ONLY: st_next.irq = rel_irq;
            default: st_next.irq = cap_irq || rel_irq;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{ctl0: CTL_RESET, ctl1: CTL_RESET, count: COUNT_RESET,
                        reload: RELOAD_RESET, match: MATCH_RESET,
                        count_low_latch: 8'h00, pre_cnt: 7'h00, out_level: 1'b0,
                        in_sync: 2'b00, in_prev: 1'b0, irq: 1'b0, rdata: 8'h00};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata = st_reg.rdata;
    assign timer_irq = st_reg.irq;
    assign timer_out = st_reg.out_level;
    // output enable low while driving; capture modes leave the pin as input
    assign timer_out_en = capture_mode;
endmodule

// [bench/rtm_props.sv]
`timescale 1ns/100ps
module rtm_props
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_in,
    input wire logic timer_out,
    input wire logic timer_out_en,
    input wire logic timer_irq
);
    logic en_reg;
    logic pol_reg;
    logic [3:0] mode_reg;
    logic cap_mode;
    // shadow of the written mode; hardware clearing of enable is not tracked
    always_ff @(posedge clock or negedge rstn)
        if (!rstn)
            {en_reg, pol_reg, mode_reg} <= '0;
        else if (reg_write && reg_addr == 12'hf07)
            {en_reg, pol_reg, mode_reg[2:0]} <= {reg_wdata[7:6], reg_wdata[2:0]};
        else if (reg_write && reg_addr == 12'hf06)
            mode_reg[3] <= reg_wdata[7];
    assign cap_mode = mode_reg == 4'h4 || mode_reg == 4'h8;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    unmapped_zero_a: assert property (
        reg_read && reg_addr[11:3] != 9'h1e0 |=> reg_rdata == 8'h00) else $error("unmapped read");
    low_byte_rw_a: assert property (
        reg_write && reg_addr == 12'hf05 ##1 reg_read && !reg_write && reg_addr == 12'hf05
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("match low readback");
    idle_level_a: assert property (
        reg_write && reg_addr == 12'hf07 && !reg_wdata[7] |-> ##2 timer_out == $past(reg_wdata[6], 2))
        else $error("idle output level");
    irq_pulse_a: assert property (
        timer_irq && !cap_mode |=> !timer_irq) else $error("irq longer than a cycle");
    disabled_quiet_a: assert property (
        !en_reg && !$past(en_reg) |-> !timer_irq) else $error("irq while disabled");
    cont_toggle_a: assert property (
        timer_irq && $past(mode_reg) == 4'h1 |-> timer_out != $past(timer_out))
        else $error("no toggle");
    pwm_restore_a: assert property (
        timer_irq && $past(mode_reg) == 4'h3 |-> timer_out == $past(pol_reg))
        else $error("pwm level at reload");
    capture_release_a: assert property (
        cap_mode && $past(cap_mode) |-> timer_out_en) else $error("pin driven in capture");
endmodule
bind rtm_timer rtm_props i_props (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_in(timer_in), .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_irq(timer_irq));

// [bench/rtm_pin_model.sv]
`timescale 1ns/100ps
module rtm_pin_model
(
    input wire logic drive_level,
    input wire logic timer_out,
    input wire logic timer_out_en,
    output logic timer_in
);
    // one shared pin: the device wins while its enable is low; source lags the clock
    assign #3 timer_in = timer_out_en ? drive_level : timer_out;
endmodule

// [bench/tb_reloadable_timer_pwm_capture.sv]
`timescale 1ns/100ps
module tb_reloadable_timer_pwm_capture;
    logic clock = 0, rstn = 0, reg_write = 0, reg_read = 0, drive_level = 0;
    logic [11:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, v, r, m;
    logic timer_in, timer_out, timer_out_en, timer_irq;
    int seed = 51069, n_errors = 0, cmp_count = 0, n, k, i;
    always #4 clock = ~clock;
    rtm_timer i_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_in(timer_in),
        .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_irq(timer_irq));
    rtm_pin_model i_pins (.drive_level(drive_level), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .timer_in(timer_in));
    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task bus(input logic w, input logic s, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= w;
        reg_read <= s;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        bus(1, 0, a, d);
        bus(0, 0, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e, input string what);
        bus(0, 1, a, 0);
        bus(0, 0, a, 0);
        #1 check(what, e, reg_rdata);
    endtask
    task wait_irq;
        n = 0;
        do
        begin
            @(posedge clock);
            // look after the edge has settled, never in the edge's own time step
            #1 n++;
        end
        while (timer_irq !== 1'b1 && n < 3000);
        check("irq", 1, timer_irq);
    endtask
    task count_irq(input int c);
        k = 0;
        repeat (c)
        begin
            @(posedge clock);
            #1 k += (timer_irq === 1'b1);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // the whole sequence needs well under 10000 cycles
    initial
    begin
        repeat (50000) @(posedge clock);
        n_errors++;
        print_verdict;
    end
    initial
    begin
        repeat (20) @(posedge clock);
        rstn <= 1;
        rd(12'hf06, 8'h00, "control zero");
        rd(12'hf00, 8'h00, "count high");
        rd(12'hf01, 8'h01, "count low");
        rd(12'hf08, 8'h00, "unmapped");
        v = $random(seed);
        bus(1, 0, 12'hf05, v);
        rd(12'hf05, v, "match low");
        $display("register test done");
        wr(12'hf02, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            r = 3 + ($random(seed) & 15);
            wr(12'hf07, 8'h01);
            wr(12'hf01, 8'h01);
            wr(12'hf03, r);
            wr(12'hf07, {2'b10, i[2:0], 3'h1});
            wait_irq;
            wait_irq;
            check("period", r << i, n);
        end
        wr(12'hf07, 8'h41);
        wr(12'hf00, 8'h12);
        wr(12'hf01, 8'h34);
        repeat (40) @(posedge clock);
        rd(12'hf00, 8'h12, "held high");
        rd(12'hf01, 8'h34, "held low");
        for (i = 0; i < 2; i++)
        begin
            m = 2 + ($random(seed) & 7);
            r = m + 1 + ($random(seed) & 7);
            wr(12'hf07, {1'b0, i[0], 6'h03});
            wr(12'hf00, 8'h00);
            wr(12'hf01, 8'h01);
            wr(12'hf04, 8'h00);
            wr(12'hf05, m);
            wr(12'hf03, r);
            wr(12'hf07, {1'b1, i[0], 6'h03});
            wait_irq;
            k = 0;
            repeat (r)
            begin
                @(posedge clock);
                #1 k += (timer_out !== i[0]);
            end
            check("pwm off time", r - m, k);
        end
        $display("continuous and pwm tests done");
        wr(12'hf07, 8'h44);
        wr(12'hf04, 8'h00);
        wr(12'hf05, 8'h00);
        wr(12'hf03, 8'h80);
        wr(12'hf01, 8'h01);
        wr(12'hf07, 8'hc4);
        drive_level <= 1;
        wait_irq;
        rd(12'hf06, 8'h01, "capture flag");
        wait_irq;
        rd(12'hf06, 8'h00, "reload flag");
        wr(12'hf06, 8'h40);
        count_irq(256);
        check("capture only", 0, k);
        drive_level <= 0;
        repeat (5) @(posedge clock);
        drive_level <= 1;
        wait_irq;
        wr(12'hf06, 8'h60);
        drive_level <= 0;
        repeat (5) @(posedge clock);
        drive_level <= 1;
        count_irq(256);
        check("reload only", 2, k);
        wr(12'hf07, 8'h00);
        wr(12'hf06, 8'h80);
        wr(12'hf02, 8'hff);
        wr(12'hf03, 8'hff);
        wr(12'hf00, 8'h80);
        wr(12'hf07, 8'h80);
        drive_level <= 0;
        wait_irq;
        rd(12'hf04, 8'h80, "captured high");
        rd(12'hf00, 8'h00, "restarted count");
        $display("capture tests done");
        r = 3 + ($random(seed) & 15);
        wr(12'hf07, 8'h00);
        wr(12'hf06, 8'h00);
        wr(12'hf00, 8'h00);
        wr(12'hf01, 8'h01);
        wr(12'hf02, 8'h00);
        wr(12'hf03, r);
        wr(12'hf07, 8'h80);
        wait_irq;
        // a one-shot must not reload a second time
        count_irq(64);
        check("one shot stop", 0, k);
        rd(12'hf07, 8'h00, "one shot enable");
        $display("one shot test done");
        print_verdict;
    end
endmodule
